// file: pkg/crtc_pkg.sv
// crtc_pkg: register indices, field positions and timing constants for the crt timing controller.
// assumes a single character clock domain; the processor port is sampled on that clock.
package crtc_pkg;

    localparam logic [4:0] REG_H_TOTAL      = 5'h00;
    localparam logic [4:0] REG_H_DISPLAYED  = 5'h01;
    localparam logic [4:0] REG_H_SYNC_POS   = 5'h02;
    localparam logic [4:0] REG_SYNC_WIDTHS  = 5'h03;
    localparam logic [4:0] REG_V_TOTAL      = 5'h04;
    localparam logic [4:0] REG_V_ADJUST     = 5'h05;
    localparam logic [4:0] REG_V_DISPLAYED  = 5'h06;
    localparam logic [4:0] REG_V_SYNC_POS   = 5'h07;
    localparam logic [4:0] REG_MODE         = 5'h08;
    localparam logic [4:0] REG_ROW_SCAN     = 5'h09;
    localparam logic [4:0] REG_CUR_START    = 5'h0a;
    localparam logic [4:0] REG_CUR_END      = 5'h0b;
    localparam logic [4:0] REG_START_HI     = 5'h0c;
    localparam logic [4:0] REG_START_LO     = 5'h0d;
    localparam logic [4:0] REG_CUR_POS_HI   = 5'h0e;
    localparam logic [4:0] REG_CUR_POS_LO   = 5'h0f;
    localparam logic [4:0] REG_PEN_HI       = 5'h10;
    localparam logic [4:0] REG_PEN_LO       = 5'h11;
    localparam logic [4:0] REG_UPD_HI       = 5'h12;
    localparam logic [4:0] REG_UPD_LO       = 5'h13;
    localparam logic [4:0] REG_DUMMY        = 5'h1f;

    // mode control bit positions
    localparam int MODE_UPDATE_TIMING = 7;
    localparam int MODE_STROBE_PIN    = 6;
    localparam int MODE_CURSOR_DELAY  = 5;
    localparam int MODE_DE_DELAY      = 4;
    localparam int MODE_REFRESH_ACC   = 3;
    localparam int MODE_ADDR_FORMAT   = 2;

    // status bit positions
    localparam int STAT_UPDATE_DONE   = 7;
    localparam int STAT_PEN_FULL      = 6;
    localparam int STAT_VRETRACE      = 5;

    // cursor blink modes, cursor start bits 6-5
    localparam logic [1:0] BLINK_STEADY = 2'h0;
    localparam logic [1:0] BLINK_OFF    = 2'h1;
    localparam logic [1:0] BLINK_16     = 2'h2;
    localparam logic [1:0] BLINK_32     = 2'h3;

    localparam int BLINK_16_BIT = 3;
    localparam int BLINK_32_BIT = 4;

    // retrace flag drops this many character clocks before the frame ends
    localparam logic [8:0] VRF_LEAD_CLOCKS = 9'h005;
    // vertical sync width value zero stands for this many scan lines
    localparam logic [4:0] VSYNC_ZERO_LINES = 5'h10;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    typedef enum logic [1:0] {
        VP_ROWS = 2'b01,
        VP_ADJ  = 2'b10
    } crtc_vphase_e;

endpackage : crtc_pkg

// file: hw/crtc_core.sv
// crtc_core: crt display timing controller with indirect register file, syncs, refresh addresses and cursor.
// assumes i_ref_clk is the character clock and the processor port signals are synchronous to it.
`timescale 1ns/10ps

// Behaviour
// - pen full status bit sets on capture, clears on reading either pen half.
// - retrace status rises at retrace start, drops five clocks before retrace ends.
// - unused bits read zero; dummy location and deselected cycles leave bus undriven.
// - horizontal total holds characters per line minus one, sets line period.
// - horizontal displayed gives characters per line with display enable active.
// - horizontal sync position gives the character where horizontal sync starts.
// - sync width bits 7-4 give vertical sync lines; zero means sixteen.
// - sync width bits 3-0 give horizontal sync width in character clocks.
// - vertical total holds character rows per frame minus one.
// - line adjust appends extra scan lines to each frame.
// - vertical displayed gives rows per frame with display enable active.
// - vertical sync position selects the row where vertical sync starts.
// - mode bit 7 picks update during blanking or interleaved immediately.
// - mode bit 6 makes top raster line output the update strobe.
// - mode bits 5 and 4 delay cursor and display enable one clock.
// - mode bit 3 selects shared or transparent refresh memory access.
// - mode bit 2 selects binary or row/column refresh addresses.
// - mode bits 1-0 select no interlace, sync interlace, or sync and video.
// - row scan lines holds scan lines per character row minus one.
// - cursor start bits 6-5 pick steady, blank, blink sixteenth or thirty-second.
// - binary refresh addresses advance from the display start address each character clock.
// - cursor active when address matches position and raster inside start-end lines.
// - rising pen strobe stores refresh address into pen register next clock.
// - select low: write loads pointer, read returns status; high reaches pointed register.
// - counter reset clears counters and outputs, keeps control registers.
// - row/column mode puts column on address bits 0-7, row on 8-13.
module crtc_core
    import crtc_pkg::*;
#(
    parameter int ADDR_W = 14
)(
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_por_n,
    input  wire logic              i_cpu_sel_n,
    input  wire logic              i_cpu_strobe,
    input  wire logic              i_register_select,
    input  wire logic              i_read_not_write,
    input  wire logic [7:0]        i_cpu_data,
    input  wire logic              i_pen_strobe_in,
    output logic      [7:0]        o_cpu_data,
    output logic                   o_cpu_data_oe,
    output logic                   o_hsync,
    output logic                   o_vsync,
    output logic                   o_display_en,
    output logic                   o_cursor,
    output logic      [ADDR_W-1:0] o_refresh_address_out,
    output logic      [4:0]        o_raster_line_out
);

    if (ADDR_W != 14)
    begin : g_check
        $error("crtc_core: refresh address width must be 14");
    end

    // control registers: reset only at power-on so counter reset keeps them
    logic [7:0]        h_total_r;
    logic [7:0]        h_disp_r;
    logic [7:0]        h_sync_pos_r;
    logic [7:0]        sync_widths_r;
    logic [6:0]        v_total_r;
    logic [4:0]        v_adjust_r;
    logic [6:0]        v_disp_r;
    logic [6:0]        v_sync_pos_r;
    logic [7:0]        mode_r;
    logic [4:0]        row_scan_r;
    logic [6:0]        cur_start_r;
    logic [4:0]        cur_end_r;
    logic [13:0]       disp_start_r;
    logic [13:0]       cur_pos_r;
    logic [13:0]       upd_addr_r;
    logic [4:0]        pointer_r;
    logic [13:0]       pen_r;
    logic              pen_full_r;
    logic              upd_done_r;
    logic              upd_pend_r;
    logic              vrf_r;

    // scan state
    crtc_vphase_e      vphase_r;
    logic [7:0]        h_cnt_r;
    logic [4:0]        sl_r;
    logic [6:0]        row_r;
    logic [4:0]        adj_r;
    logic [13:0]       row_start_r;
    logic              field_r;
    logic [4:0]        blink_r;
    logic [3:0]        hs_left_r;
    logic [4:0]        vs_left_r;
    logic              de_d_r;
    logic              cur_d_r;
    logic              pen_prev_r;
    logic              pen_arm_r;

    logic              acc;
    logic              wr_reg;
    logic              rd_reg;
    logic              h_last;
    logic              sl_last;
    logic              row_last;
    logic              frame_last_line;
    logic              video_ilv;
    logic [4:0]        sl_first;
    logic [7:0]        vs_point;
    logic              vs_tick;
    logic              vs_start;
    logic              hs_start;
    logic [3:0]        hs_width;
    logic [4:0]        vs_width;
    logic              de_raw;
    logic [13:0]       ma_raw;
    logic              cur_raw;
    logic              upd_go;
    logic              dummy_hit;

    function automatic logic cursor_visible(input logic [1:0] mode, input logic [4:0] blink);
        logic vis;
        vis = 1'b0;
        case (mode)
            BLINK_STEADY: vis = 1'b1;
            BLINK_OFF:    vis = 1'b0;
            BLINK_16:     vis = blink[BLINK_16_BIT];
            BLINK_32:     vis = blink[BLINK_32_BIT];
            default:      vis = 1'b0;
        endcase
        return vis;
    endfunction : cursor_visible

    assign acc       = i_cpu_strobe & ~i_cpu_sel_n;
    assign wr_reg    = acc & i_register_select & ~i_read_not_write;
    assign rd_reg    = acc & i_register_select & i_read_not_write;
    assign dummy_hit = acc & i_register_select & (pointer_r == REG_DUMMY);

    // pointer and status through select low
    always_ff @(posedge i_ref_clk or negedge i_por_n)
    begin
        if (!i_por_n)
            pointer_r <= 5'h00;
        else if (acc && !i_register_select && !i_read_not_write)
            pointer_r <= i_cpu_data[4:0];
    end

    always_ff @(posedge i_ref_clk or negedge i_por_n)
    begin
        if (!i_por_n)
        begin
            h_total_r     <= REG_RESET_VALUE;
            h_disp_r      <= REG_RESET_VALUE;
            h_sync_pos_r  <= REG_RESET_VALUE;
            sync_widths_r <= REG_RESET_VALUE;
            v_total_r     <= 7'h00;
            v_adjust_r    <= 5'h00;
            v_disp_r      <= 7'h00;
            v_sync_pos_r  <= 7'h00;
            mode_r        <= REG_RESET_VALUE;
            row_scan_r    <= 5'h00;
            cur_start_r   <= 7'h00;
            cur_end_r     <= 5'h00;
            disp_start_r  <= 14'h0000;
            cur_pos_r     <= 14'h0000;
        end
        else if (wr_reg)
        begin
            case (pointer_r)
                REG_H_TOTAL:     h_total_r     <= i_cpu_data;
                REG_H_DISPLAYED: h_disp_r      <= i_cpu_data;
                REG_H_SYNC_POS:  h_sync_pos_r  <= i_cpu_data;
                REG_SYNC_WIDTHS: sync_widths_r <= i_cpu_data;
                REG_V_TOTAL:     v_total_r     <= i_cpu_data[6:0];
                REG_V_ADJUST:    v_adjust_r    <= i_cpu_data[4:0];
                REG_V_DISPLAYED: v_disp_r      <= i_cpu_data[6:0];
                REG_V_SYNC_POS:  v_sync_pos_r  <= i_cpu_data[6:0];
                REG_MODE:        mode_r        <= i_cpu_data;
                REG_ROW_SCAN:    row_scan_r    <= i_cpu_data[4:0];
                REG_CUR_START:   cur_start_r   <= i_cpu_data[6:0];
                REG_CUR_END:     cur_end_r     <= i_cpu_data[4:0];
                REG_START_HI:    disp_start_r[13:8] <= i_cpu_data[5:0];
                REG_START_LO:    disp_start_r[7:0]  <= i_cpu_data;
                REG_CUR_POS_HI:  cur_pos_r[13:8]    <= i_cpu_data[5:0];
                REG_CUR_POS_LO:  cur_pos_r[7:0]     <= i_cpu_data;
                default:         ;
            endcase
        end
    end

    // read path: one registered cycle of drive per read
    always_ff @(posedge i_ref_clk or negedge i_por_n)
    begin
        if (!i_por_n)
        begin
            o_cpu_data    <= 8'h00;
            o_cpu_data_oe <= 1'b0;
        end
        else
        begin
            o_cpu_data    <= 8'h00;
            o_cpu_data_oe <= 1'b0;
            if (acc && i_read_not_write && !i_register_select)
            begin
                o_cpu_data    <= {upd_done_r, pen_full_r, vrf_r, 5'h00};
                o_cpu_data_oe <= 1'b1;
            end
            else if (rd_reg && pointer_r != REG_DUMMY)
            begin
                o_cpu_data_oe <= 1'b1;
                case (pointer_r)
                    REG_CUR_POS_HI: o_cpu_data <= {2'h0, cur_pos_r[13:8]};
                    REG_CUR_POS_LO: o_cpu_data <= cur_pos_r[7:0];
                    REG_PEN_HI:     o_cpu_data <= {2'h0, pen_r[13:8]};
                    REG_PEN_LO:     o_cpu_data <= pen_r[7:0];
                    default:        o_cpu_data <= 8'h00;
                endcase
            end
        end
    end

    // light pen capture one clock after the rising edge; set wins over read clear
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pen_prev_r <= 1'b0;
            pen_arm_r  <= 1'b0;
        end
        else
        begin
            pen_prev_r <= i_pen_strobe_in;
            pen_arm_r  <= i_pen_strobe_in & ~pen_prev_r;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_por_n)
    begin
        if (!i_por_n)
        begin
            pen_r      <= 14'h0000;
            pen_full_r <= 1'b0;
        end
        else if (pen_arm_r)
        begin
            pen_r      <= ma_raw;
            pen_full_r <= 1'b1;
        end
        else if (rd_reg && (pointer_r == REG_PEN_HI || pointer_r == REG_PEN_LO))
            pen_full_r <= 1'b0;
    end

    // transparent update: a dummy access queues one refresh memory cycle
    assign upd_go = upd_pend_r & (mode_r[MODE_UPDATE_TIMING] | ~de_raw);

    always_ff @(posedge i_ref_clk or negedge i_por_n)
    begin
        if (!i_por_n)
        begin
            upd_addr_r <= 14'h0000;
            upd_pend_r <= 1'b0;
            upd_done_r <= 1'b0;
        end
        else
        begin
            if (wr_reg && pointer_r == REG_UPD_HI)
                upd_addr_r[13:8] <= i_cpu_data[5:0];
            else if (wr_reg && pointer_r == REG_UPD_LO)
                upd_addr_r[7:0] <= i_cpu_data;
            else if (upd_go)
                upd_addr_r <= upd_addr_r + 14'h0001;
            if (dummy_hit && mode_r[MODE_REFRESH_ACC])
                upd_pend_r <= 1'b1;
            else if (upd_go)
                upd_pend_r <= 1'b0;
            if (upd_go)
                upd_done_r <= 1'b1;
            else if (wr_reg && (pointer_r == REG_UPD_HI || pointer_r == REG_UPD_LO))
                upd_done_r <= 1'b0;
        end
    end

    // scan geometry
    assign video_ilv = (mode_r[1:0] == 2'h3);
    assign sl_first  = video_ilv ? {4'h0, field_r} : 5'h00;
    assign h_last    = (h_cnt_r == h_total_r);
    assign sl_last   = (sl_r == row_scan_r) || (video_ilv && ({1'b0, sl_r} + 6'h01 == {1'b0, row_scan_r}));
    assign row_last  = (row_r == v_total_r);
    assign frame_last_line = (vphase_r == VP_ROWS && sl_last && row_last && v_adjust_r == 5'h00) ||
                             (vphase_r == VP_ADJ && adj_r + 5'h01 == v_adjust_r);

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            h_cnt_r <= 8'h00;
        else if (h_last)
            h_cnt_r <= 8'h00;
        else
            h_cnt_r <= h_cnt_r + 8'h01;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            vphase_r    <= VP_ROWS;
            sl_r        <= 5'h00;
            row_r       <= 7'h00;
            adj_r       <= 5'h00;
            row_start_r <= 14'h0000;
            field_r     <= 1'b0;
            blink_r     <= 5'h00;
        end
        else if (h_last)
        begin
            case (vphase_r)
                VP_ROWS:
                begin
                    if (frame_last_line)
                    begin
                        row_r       <= 7'h00;
                        row_start_r <= disp_start_r;
                        field_r     <= mode_r[0] & ~field_r;
                        sl_r        <= video_ilv ? {4'h0, ~field_r} : 5'h00;
                        blink_r     <= blink_r + 5'h01;
                    end
                    else if (sl_last && row_last)
                    begin
                        vphase_r <= VP_ADJ;
                        adj_r    <= 5'h00;
                        sl_r     <= 5'h00;
                    end
                    else if (sl_last)
                    begin
                        sl_r        <= sl_first;
                        row_r       <= row_r + 7'h01;
                        row_start_r <= row_start_r + {6'h00, h_disp_r};
                    end
                    else
                        sl_r <= sl_r + (video_ilv ? 5'h02 : 5'h01);
                end
                VP_ADJ:
                begin
                    if (frame_last_line)
                    begin
                        vphase_r    <= VP_ROWS;
                        row_r       <= 7'h00;
                        row_start_r <= disp_start_r;
                        field_r     <= mode_r[0] & ~field_r;
                        sl_r        <= video_ilv ? {4'h0, ~field_r} : 5'h00;
                        blink_r     <= blink_r + 5'h01;
                    end
                    else
                    begin
                        adj_r <= adj_r + 5'h01;
                        sl_r  <= sl_r + 5'h01;
                    end
                end
                default: vphase_r <= VP_ROWS;
            endcase
        end
    end

    // horizontal sync; a zero width gives no pulse
    assign hs_start = (h_cnt_r == h_sync_pos_r);
    assign hs_width = sync_widths_r[3:0];

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            hs_left_r <= 4'h0;
            o_hsync   <= 1'b0;
        end
        else if (hs_start)
        begin
            hs_left_r <= hs_width;
            o_hsync   <= (hs_width != 4'h0);
        end
        else
        begin
            hs_left_r <= (hs_left_r != 4'h0) ? hs_left_r - 4'h1 : 4'h0;
            o_hsync   <= (hs_left_r > 4'h1);
        end
    end

    // vertical sync counted in lines; odd sync-interlace fields start half a line late
    assign vs_point = (mode_r[0] && field_r) ? {1'b0, h_total_r[7:1]} : 8'h00;
    assign vs_tick  = (h_cnt_r == vs_point);
    assign vs_start = vs_tick && vphase_r == VP_ROWS && row_r == v_sync_pos_r && sl_r == sl_first;
    assign vs_width = (sync_widths_r[7:4] == 4'h0) ? VSYNC_ZERO_LINES : {1'b0, sync_widths_r[7:4]};

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            vs_left_r <= 5'h00;
            o_vsync   <= 1'b0;
        end
        else if (vs_tick)
        begin
            if (vs_start && vs_left_r == 5'h00)
            begin
                vs_left_r <= vs_width;
                o_vsync   <= 1'b1;
            end
            else if (vs_left_r != 5'h00)
            begin
                vs_left_r <= vs_left_r - 5'h01;
                o_vsync   <= (vs_left_r > 5'h01);
            end
        end
    end

    // retrace flag clears early so software stays clear of the frame turnover
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            vrf_r <= 1'b0;
        else if (h_last && vphase_r == VP_ROWS && sl_last && row_r + 7'h01 == v_disp_r)
            vrf_r <= 1'b1;
        else if (frame_last_line && {1'b0, h_cnt_r} + VRF_LEAD_CLOCKS == {1'b0, h_total_r})
            vrf_r <= 1'b0;
    end

    // refresh address, display enable and cursor
    assign de_raw  = (h_cnt_r < h_disp_r) && vphase_r == VP_ROWS && (row_r < v_disp_r);
    assign ma_raw  = mode_r[MODE_ADDR_FORMAT] ? {row_r[5:0], h_cnt_r}
                                              : row_start_r + {6'h00, h_cnt_r};
    assign cur_raw = (ma_raw == cur_pos_r) && (sl_r >= cur_start_r[4:0]) && (sl_r <= cur_end_r) &&
                     cursor_visible(cur_start_r[6:5], blink_r);

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            de_d_r       <= 1'b0;
            cur_d_r      <= 1'b0;
            o_display_en <= 1'b0;
            o_cursor     <= 1'b0;
        end
        else
        begin
            de_d_r       <= de_raw;
            cur_d_r      <= cur_raw;
            o_display_en <= mode_r[MODE_DE_DELAY] ? de_d_r : de_raw;
            o_cursor     <= mode_r[MODE_CURSOR_DELAY] ? cur_d_r : cur_raw;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_refresh_address_out <= '0;
            o_raster_line_out     <= 5'h00;
        end
        else
        begin
            o_refresh_address_out <= upd_go ? upd_addr_r : ma_raw;
            o_raster_line_out     <= {mode_r[MODE_STROBE_PIN] ? upd_go : sl_r[4], sl_r[3:0]};
        end
    end

endmodule : crtc_core

// file: test/crtc_core_properties.sv
// crtc_core_properties: port checker for crtc_core, bound after the module.
// assumes one character clock; power-on reset disables every property.
`timescale 1ns/10ps
module crtc_core_checker
#(
    parameter int ADDR_W = 14
)(
    input wire logic              i_ref_clk,
    input wire logic              i_resetn,
    input wire logic              i_por_n,
    input wire logic              i_cpu_sel_n,
    input wire logic              i_cpu_strobe,
    input wire logic              i_register_select,
    input wire logic              i_read_not_write,
    input wire logic [7:0]        o_cpu_data,
    input wire logic              o_cpu_data_oe,
    input wire logic              o_hsync,
    input wire logic              o_display_en,
    input wire logic [ADDR_W-1:0] o_refresh_address_out
);
    logic [4:0] hs_len_r;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_por_n);
    // saturates so a stuck sync cannot wrap back into range
    always_ff @(posedge i_ref_clk or negedge i_por_n)
    begin
        if (!i_por_n)
            hs_len_r <= 5'h00;
        else if (!o_hsync)
            hs_len_r <= 5'h00;
        else if (hs_len_r != 5'h1f)
            hs_len_r <= hs_len_r + 5'h01;
    end
    a_deselect_quiet: assert property (i_cpu_sel_n |=> !o_cpu_data_oe) else $error("bus driven while deselected");
    a_idle_no_drive: assert property (!i_cpu_strobe |=> !o_cpu_data_oe) else $error("bus driven without access");
    a_write_no_drive: assert property (i_cpu_strobe && !i_cpu_sel_n && !i_read_not_write |=> !o_cpu_data_oe)
        else $error("bus driven after write");
    a_oe_needs_read: assert property (o_cpu_data_oe |-> $past(i_cpu_strobe && i_read_not_write))
        else $error("bus driven without read");
    a_idle_data_zero: assert property (!o_cpu_data_oe |-> o_cpu_data == 8'h00) else $error("idle data nonzero");
    a_status_read_drives: assert property (i_cpu_strobe && !i_cpu_sel_n && !i_register_select && i_read_not_write
        |=> o_cpu_data_oe && o_cpu_data[4:0] == 5'h00) else $error("status read wrong");
    a_reset_outputs_low: assert property (!i_resetn |-> !o_hsync && !o_display_en && o_refresh_address_out == '0)
        else $error("outputs active in counter reset");
    a_hsync_width_max: assert property (o_hsync |-> hs_len_r < 5'h0f) else $error("hsync wider than 15");
endmodule : crtc_core_checker
bind crtc_core crtc_core_checker #(.ADDR_W(ADDR_W)) u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_por_n(i_por_n), .i_cpu_sel_n(i_cpu_sel_n), .i_cpu_strobe(i_cpu_strobe), .i_register_select(i_register_select),
    .i_read_not_write(i_read_not_write), .o_cpu_data(o_cpu_data), .o_cpu_data_oe(o_cpu_data_oe), .o_hsync(o_hsync),
    .o_display_en(o_display_en), .o_refresh_address_out(o_refresh_address_out));

// file: test/crtc_video_model.sv
// crtc_video_model: monitor side of the video port plus a light pen.
// assumes counts are read in the cycle i_measure falls, before the next clock clears them.
`timescale 1ns/10ps
module crtc_video_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_hsync,
    input  wire logic       i_vsync,
    input  wire logic       i_display_en,
    input  wire logic       i_cursor,
    input  wire logic       i_measure,
    output logic            o_pen_strobe_in,
    output logic [7:0]      o_cnt[6]
);
    logic hs_q;
    logic vs_q;
    initial o_pen_strobe_in = 1'b0;
    always @(posedge i_ref_clk)
    begin
        hs_q <= i_hsync;
        vs_q <= i_vsync;
        for (int i = 0; i < 6; i++)
            if (!i_measure)
                o_cnt[i] <= 8'h00;
        if (i_measure)
        begin
            o_cnt[0] <= o_cnt[0] + 8'(i_hsync && !hs_q);
            o_cnt[1] <= o_cnt[1] + 8'(i_hsync);
            o_cnt[2] <= o_cnt[2] + 8'(i_vsync && !vs_q);
            o_cnt[3] <= o_cnt[3] + 8'(i_vsync);
            o_cnt[4] <= o_cnt[4] + 8'(i_display_en);
            o_cnt[5] <= o_cnt[5] + 8'(i_cursor);
        end
    end
    // pen held several clocks, as a real photodiode pulse would be
    task automatic fire_pen;
        @(posedge i_ref_clk);
        #1 o_pen_strobe_in = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1 o_pen_strobe_in = 1'b0;
    endtask : fire_pen
endmodule : crtc_video_model

// file: test/crtc_core_tb_top.sv
// crtc_core_tb_top: programs a small raster and checks bus, timing, cursor and pen.
// assumes the checker is bound and the video model is compiled.
`timescale 1ns/10ps
module crtc_core_tb_top;
    import crtc_pkg::*;
    logic       clk = 0, rstn = 0, por_n = 0, sel_n = 1, stb = 0, rs = 0, rnw = 0, meas = 0;
    logic       oe, hs, vs, de, cur, pen;
    logic [7:0] wd = 8'h00, rd, cnt[6];
    logic [13:0] ma;
    logic [4:0] ra;
    int         err_count = 0, n_compared = 0, vertical_retrace_flag;
    // 10 chars a line, 2 lines a row, 4 rows plus 1 adjust line: 90 clocks a frame
    logic [7:0] prog[16] = '{8'h09, 8'h06, 8'h07, 8'h22, 8'h03, 8'h01, 8'h02, 8'h03,
                             8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    crtc_core uut (.i_ref_clk(clk), .i_resetn(rstn), .i_por_n(por_n), .i_cpu_sel_n(sel_n), .i_cpu_strobe(stb),
        .i_register_select(rs), .i_read_not_write(rnw), .i_cpu_data(wd), .i_pen_strobe_in(pen), .o_cpu_data(rd),
        .o_cpu_data_oe(oe), .o_hsync(hs), .o_vsync(vs), .o_display_en(de), .o_cursor(cur),
        .o_refresh_address_out(ma), .o_raster_line_out(ra));
    crtc_video_model mdl (.i_ref_clk(clk), .i_hsync(hs), .i_vsync(vs), .i_display_en(de), .i_cursor(cur),
        .i_measure(meas), .o_pen_strobe_in(pen), .o_cnt(cnt));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic a_rs, input logic a_rnw, input logic [7:0] d);
        @(posedge clk);
        #1 stb = 1;
        sel_n = 0;
        rs = a_rs;
        rnw = a_rnw;
        wd = d;
        @(posedge clk);
        #1 stb = 0;
        sel_n = 1;
    endtask : acc
    task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
        acc(0, 0, {3'h0, a});
        acc(1, 0, d);
    endtask : reg_wr
    task automatic reg_rd(input logic [4:0] a);
        acc(0, 0, {3'h0, a});
        acc(1, 1, 8'h00);
    endtask : reg_rd
    task automatic measure;
        @(posedge clk);
        #1 meas = 1;
        repeat (90) @(posedge clk);
        #1 meas = 0;
    endtask : measure
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        #500000 err_count++;
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rstn = 1;
        por_n = 1;
        reg_wr(REG_CUR_POS_HI, 8'hff);
        reg_rd(REG_CUR_POS_HI);
        check(rd, 8'h3f);
        for (int i = 0; i < 16; i++)
            reg_wr(5'(i), prog[i]);
        reg_rd(REG_H_TOTAL);
        check({7'h0, oe}, 8'h01);
        check(rd, 8'h00);
        reg_rd(REG_DUMMY);
        check({7'h0, oe}, 8'h00);
        repeat (200) @(posedge clk);
        measure();
        check(cnt[0], 8'd9);
        check(cnt[1], 8'd18);
        check(cnt[2], 8'd1);
        check(cnt[3], 8'd20);
        check(cnt[4], 8'd24);
        check(cnt[5], 8'd2);
        // back-to-back status reads over exactly one frame
        @(posedge clk);
        #1 stb = 1;
        sel_n = 0;
        rs = 0;
        rnw = 1;
        vertical_retrace_flag = 0;
        repeat (90)
        begin
            @(posedge clk);
            #1 vertical_retrace_flag += rd[5];
        end
        stb = 0;
        sel_n = 1;
        check(8'(vertical_retrace_flag), 8'd45);
        reg_wr(REG_CUR_START, {1'b0, BLINK_OFF, 5'h00});
        measure();
        check(cnt[5], 8'd0);
        mdl.fire_pen();
        acc(0, 1, 8'h00);
        check({7'h0, rd[6]}, 8'h01);
        reg_rd(REG_PEN_HI);
        check({6'h0, rd[7:6]}, 8'h00);
        acc(0, 1, 8'h00);
        check({7'h0, rd[6]}, 8'h00);
        reg_wr(REG_CUR_POS_LO, 8'h5a);
        @(posedge clk);
        #1 rstn = 0;
        repeat (3) @(posedge clk);
        check({1'b0, vs, cur, ra}, 8'h00);
        #1 rstn = 1;
        reg_rd(REG_CUR_POS_LO);
        check(rd, 8'h5a);
        end_sim();
    end
endmodule : crtc_core_tb_top
